// ===== shared/ofd_pkg.sv
// Constants and types for the opcode field decoder.
// Assumes one clock domain and bytes arriving in program order.
`default_nettype none
package ofd_pkg;
  localparam logic [7:0] OFD_RESET_BYTE = 8'h00;
  localparam logic [2:0] OFD_RESET_CNT = 3'h0;
  localparam logic [3:0] OFD_RESET_COND = 4'h0;
  localparam logic [5:0] OFD_RESET_HAND = 6'h00;
  // Operation classes
  typedef enum logic [5:0] {
    OFD_NONE, OFD_SUM, OFD_SUM_CARRY, OFD_DIFF, OFD_DIFF_BORROW,
    OFD_PLUS_ONE, OFD_MINUS_ONE, OFD_TWOS_COMP, OFD_COMPARE,
    OFD_ASCII_FIX, OFD_BCD_FIX, OFD_BR_NEAR, OFD_BR_SHORT, OFD_BR_FAR,
    OFD_BR_IND_NEAR, OFD_BR_IND_FAR, OFD_EXIT_NEAR, OFD_EXIT_FAR,
    OFD_BR_COND, OFD_COUNT_BR, OFD_COUNT_BR_ZERO, OFD_COUNT_BR_NONZERO,
    OFD_BR_CNT_ZERO, OFD_TRAP_VEC, OFD_TRAP3, OFD_TRAP_OVF,
    OFD_TRAP_EXIT, OFD_LOCK, OFD_HALT, OFD_COPROC_SYNC, OFD_HAND_OFF,
    OFD_UNKNOWN
  } ofd_op_t;
  typedef enum {OFD_ST_OPC, OFD_ST_MODRM, OFD_ST_TAIL} ofd_state_t;
endpackage
`default_nettype wire

// ===== rtl/ofd_decoder.sv
// Opcode field decoder: classifies first bytes and counts following bytes.
// Assumes byte_valid/byte_ready handshake from the prefetch queue.
// Overview of operation
// - 000000/000100/001010/000110 select arithmetic with modrm byte.
// - Immediate group op from modrm reg field; second byte if s:w 01.
// - Accumulator immediate forms take one data byte, two when w set.
// - ASCII and decimal sum fixups are single bytes.
// - Compare: 001110dw with modrm, or immediate group reg field 111.
// - E9 two bytes, EB one, EA four; FF reg 4/5 indirect branches.
// - Exits C3 near, CB far; C2 and CA add two immediate bytes.
// - 0111cccc branches take one displacement; low nibble is condition.
// - E0..E3 counted branches with one displacement byte.
// - CD takes a vector byte; CC, CE, CF are single bytes.
// - Lock prefix, halt and coprocessor sync carry no operand bytes.
// - 11011xxx always fetches modrm and passes low bits and middle field.
`default_nettype none
module ofd_decoder (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready,
  output logic dec_valid,
  output ofd_pkg::ofd_op_t dec_op,
  output logic [7:0] dec_opcode,
  output logic [7:0] dec_modrm,
  output logic dec_has_modrm,
  output logic dec_wide,
  output logic dec_dir,
  output logic dec_sign_ext,
  output logic [3:0] dec_cond,
  output logic [5:0] dec_hand_off,
  output logic [2:0] dec_disp_bytes,
  output logic [2:0] dec_imm_bytes
);
  ofd_pkg::ofd_state_t st_q, st_d;
  logic [7:0] opc_q;
  logic [2:0] left_q;
  logic [2:0] imm_q;
  ofd_pkg::ofd_op_t op_q;
  logic take;

  // Never stalls: every byte is decoded in the cycle it arrives
  assign byte_ready = 1'b1;
  assign take = byte_valid;

  // First-byte decode
  wire [7:0] b = byte_data;
  // Only 0100xxxx steps a register; 0101xxxx stays unknown
  wire is_step_reg = (b[7:4] == 4'b0100);
  wire is_alu_rm = (b[7:2] == 6'b000000) || (b[7:2] == 6'b000100) ||
    (b[7:2] == 6'b001010) || (b[7:2] == 6'b000110) ||
    (b[7:2] == 6'b001110);
  wire is_alu_acc = (b[7:1] == 7'b0000010) || (b[7:1] == 7'b0001010) ||
    (b[7:1] == 7'b0010110) || (b[7:1] == 7'b0001110);
  wire is_imm_grp = (b[7:2] == 6'b100000);
  wire is_ff_grp = (b[7:1] == 7'b1111111);
  wire is_neg_grp = (b[7:1] == 7'b1111011);
  wire is_esc = (b[7:3] == 5'b11011);
  wire is_jcc = (b[7:4] == 4'b0111);
  wire needs_modrm = is_alu_rm | is_imm_grp | is_ff_grp | is_neg_grp |
    is_esc;
  // Immediate count known from the first byte alone
  wire [2:0] imm_grp_n = (b[1:0] == 2'b01) ? 3'h2 : 3'h1;
  wire [2:0] acc_n = b[0] ? 3'h2 : 3'h1;

  // Unknown first bytes fall through as one-byte instructions
  logic [2:0] first_imm;
  ofd_pkg::ofd_op_t first_op;
  always_comb begin
    first_imm = 3'h0;
    first_op = ofd_pkg::OFD_UNKNOWN;
    if (is_alu_rm) begin
      case (b[5:3])
        3'b000: first_op = ofd_pkg::OFD_SUM;
        3'b010: first_op = ofd_pkg::OFD_SUM_CARRY;
        3'b101: first_op = ofd_pkg::OFD_DIFF;
        3'b011: first_op = ofd_pkg::OFD_DIFF_BORROW;
        3'b111: first_op = ofd_pkg::OFD_COMPARE;
        default: first_op = ofd_pkg::OFD_UNKNOWN;
      endcase
    end else if (is_alu_acc) begin
      first_imm = acc_n;
      case (b[5:3])
        3'b000: first_op = ofd_pkg::OFD_SUM;
        3'b010: first_op = ofd_pkg::OFD_SUM_CARRY;
        3'b101: first_op = ofd_pkg::OFD_DIFF;
        default: first_op = ofd_pkg::OFD_DIFF_BORROW;
      endcase
    end else if (is_imm_grp) begin
      first_imm = imm_grp_n;
      first_op = ofd_pkg::OFD_NONE;
    end else if (is_ff_grp || is_neg_grp || is_esc) begin
      first_op = ofd_pkg::OFD_NONE;
      if (is_esc) first_op = ofd_pkg::OFD_HAND_OFF;
    end else if (is_step_reg) begin
      first_op = b[3] ? ofd_pkg::OFD_MINUS_ONE
                      : ofd_pkg::OFD_PLUS_ONE;
    end else if (is_jcc) begin
      first_imm = 3'h1;
      first_op = ofd_pkg::OFD_BR_COND;
    end else begin
      case (b)
        8'h37: first_op = ofd_pkg::OFD_ASCII_FIX;
        8'h27: first_op = ofd_pkg::OFD_BCD_FIX;
        8'hE9: begin
          first_op = ofd_pkg::OFD_BR_NEAR;
          first_imm = 3'h2;
        end
        8'hEB: begin
          first_op = ofd_pkg::OFD_BR_SHORT;
          first_imm = 3'h1;
        end
        8'hEA: begin
          first_op = ofd_pkg::OFD_BR_FAR;
          first_imm = 3'h4;
        end
        8'hC3: first_op = ofd_pkg::OFD_EXIT_NEAR;
        8'hCB: first_op = ofd_pkg::OFD_EXIT_FAR;
        8'hC2: begin
          first_op = ofd_pkg::OFD_EXIT_NEAR;
          first_imm = 3'h2;
        end
        8'hCA: begin
          first_op = ofd_pkg::OFD_EXIT_FAR;
          first_imm = 3'h2;
        end
        8'hE2: begin
          first_op = ofd_pkg::OFD_COUNT_BR;
          first_imm = 3'h1;
        end
        8'hE1: begin
          first_op = ofd_pkg::OFD_COUNT_BR_ZERO;
          first_imm = 3'h1;
        end
        8'hE0: begin
          first_op = ofd_pkg::OFD_COUNT_BR_NONZERO;
          first_imm = 3'h1;
        end
        8'hE3: begin
          first_op = ofd_pkg::OFD_BR_CNT_ZERO;
          first_imm = 3'h1;
        end
        8'hCD: begin
          first_op = ofd_pkg::OFD_TRAP_VEC;
          first_imm = 3'h1;
        end
        8'hCC: first_op = ofd_pkg::OFD_TRAP3;
        8'hCE: first_op = ofd_pkg::OFD_TRAP_OVF;
        8'hCF: first_op = ofd_pkg::OFD_TRAP_EXIT;
        8'hF0: first_op = ofd_pkg::OFD_LOCK;
        8'hF4: first_op = ofd_pkg::OFD_HALT;
        8'h9B: first_op = ofd_pkg::OFD_COPROC_SYNC;
        default: first_op = ofd_pkg::OFD_UNKNOWN;
      endcase
    end
  end

  // Second-byte decode for group opcodes held in opc_q
  wire [2:0] mid = b[5:3];
  wire [1:0] mod = b[7:6];
  // Direct address form (mod 00, r/m 110) carries two bytes
  wire [2:0] disp_n = (mod == 2'b01) ? 3'h1 :
    (mod == 2'b10) ? 3'h2 :
    ((mod == 2'b00) && (b[2:0] == 3'b110)) ? 3'h2 : 3'h0;
  wire grp_imm = (opc_q[7:2] == 6'b100000);
  wire grp_ff = (opc_q[7:1] == 7'b1111111);
  wire grp_neg = (opc_q[7:1] == 7'b1111011);
  // Indirect branches exist only in the word form of this group
  wire ff_word = opc_q[0];

  ofd_pkg::ofd_op_t grp_op;
  always_comb begin
    grp_op = op_q;
    if (grp_imm) begin
      case (mid)
        3'b000: grp_op = ofd_pkg::OFD_SUM;
        3'b010: grp_op = ofd_pkg::OFD_SUM_CARRY;
        3'b101: grp_op = ofd_pkg::OFD_DIFF;
        3'b011: grp_op = ofd_pkg::OFD_DIFF_BORROW;
        3'b111: grp_op = ofd_pkg::OFD_COMPARE;
        default: grp_op = ofd_pkg::OFD_UNKNOWN;
      endcase
    end else if (grp_ff) begin
      case (mid)
        3'b000: grp_op = ofd_pkg::OFD_PLUS_ONE;
        3'b001: grp_op = ofd_pkg::OFD_MINUS_ONE;
        3'b100: grp_op = ff_word ? ofd_pkg::OFD_BR_IND_NEAR
                                 : ofd_pkg::OFD_UNKNOWN;
        3'b101: grp_op = ff_word ? ofd_pkg::OFD_BR_IND_FAR
                                 : ofd_pkg::OFD_UNKNOWN;
        default: grp_op = ofd_pkg::OFD_UNKNOWN;
      endcase
    end else if (grp_neg) begin
      grp_op = (mid == 3'b011) ? ofd_pkg::OFD_TWOS_COMP
                               : ofd_pkg::OFD_UNKNOWN;
    end
  end

  // Tail bytes after modrm: displacement first, then immediate
  wire [2:0] tail_n = disp_n + imm_q;
  // Which byte of the instruction this edge takes
  wire take_opc = take && (st_q == ofd_pkg::OFD_ST_OPC);
  wire take_modrm = take && (st_q == ofd_pkg::OFD_ST_MODRM);
  wire take_tail = take && (st_q == ofd_pkg::OFD_ST_TAIL);
  wire done_opc = take_opc && !needs_modrm && (first_imm == 3'h0);
  wire done_modrm = take_modrm && (tail_n == 3'h0);
  wire done_tail = take_tail && (left_q == 3'h1);

  // Byte position: opcode, then modrm, then tail bytes
  always_comb begin
    st_d = st_q;
    if (take) begin
      case (st_q)
        ofd_pkg::OFD_ST_OPC:
          if (needs_modrm) st_d = ofd_pkg::OFD_ST_MODRM;
          else if (first_imm != 3'h0) st_d = ofd_pkg::OFD_ST_TAIL;
        ofd_pkg::OFD_ST_MODRM:
          st_d = (tail_n == 3'h0) ? ofd_pkg::OFD_ST_OPC
                                  : ofd_pkg::OFD_ST_TAIL;
        ofd_pkg::OFD_ST_TAIL:
          if (left_q == 3'h1) st_d = ofd_pkg::OFD_ST_OPC;
        default: st_d = ofd_pkg::OFD_ST_OPC;
      endcase
    end
  end

  // Tail counter runs down; no byte is ever refused
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= ofd_pkg::OFD_ST_OPC;
      opc_q <= ofd_pkg::OFD_RESET_BYTE;
      left_q <= ofd_pkg::OFD_RESET_CNT;
      imm_q <= ofd_pkg::OFD_RESET_CNT;
      op_q <= ofd_pkg::OFD_NONE;
    end else begin
      st_q <= st_d;
      if (take_opc) begin
        opc_q <= b;
        op_q <= first_op;
        imm_q <= first_imm;
        left_q <= first_imm;
      end else if (take_modrm) begin
        op_q <= grp_op;
        left_q <= tail_n;
      end else if (take_tail) begin
        left_q <= left_q - 3'h1;
      end
    end
  end

  // Completion pulse, one cycle after the last byte is taken
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= done_opc | done_modrm | done_tail;
    end
  end

  // Fields hold until the next first byte; sample them at dec_valid
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dec_op <= ofd_pkg::OFD_NONE;
      dec_opcode <= ofd_pkg::OFD_RESET_BYTE;
      dec_modrm <= ofd_pkg::OFD_RESET_BYTE;
      dec_has_modrm <= 1'b0;
      dec_wide <= 1'b0;
      dec_dir <= 1'b0;
      dec_sign_ext <= 1'b0;
      dec_cond <= ofd_pkg::OFD_RESET_COND;
      dec_hand_off <= ofd_pkg::OFD_RESET_HAND;
      dec_disp_bytes <= ofd_pkg::OFD_RESET_CNT;
      dec_imm_bytes <= ofd_pkg::OFD_RESET_CNT;
    end else begin
      if (take_opc) begin
        dec_opcode <= b;
        dec_op <= first_op;
        dec_has_modrm <= needs_modrm;
        dec_modrm <= ofd_pkg::OFD_RESET_BYTE;
        dec_wide <= b[0];
        dec_dir <= b[1] & ~is_imm_grp;
        dec_sign_ext <= b[1] & is_imm_grp;
        dec_cond <= b[3:0];
        dec_hand_off <= {b[2:0], 3'b000};
        dec_disp_bytes <= ofd_pkg::OFD_RESET_CNT;
        dec_imm_bytes <= first_imm;
      end else if (take_modrm) begin
        dec_modrm <= b;
        dec_op <= grp_op;
        dec_disp_bytes <= disp_n;
        dec_hand_off <= {opc_q[2:0], mid};
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/ofd_queue_model.sv
// Prefetch queue model: offers one byte per edge in program order.
// Assumes the bench pushes bytes and drives stall after each edge.
`default_nettype none
module ofd_queue_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic byte_ready,
  input wire logic stall,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] fifo [$];
  logic [7:0] last_q = 8'h00;
  logic hold;
  task automatic push(input logic [7:0] b);
    fifo.push_back(b);
  endtask
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'hFF;
  end
  // Idle data is inverted so a stale byte never matches by luck
  always @(posedge core_clk) begin
    hold = stall;
    #1;
    if (reset_n && byte_ready && !hold && fifo.size() != 0) begin
      last_q = fifo.pop_front();
      byte_valid = 1'b1;
      byte_data = last_q;
    end else begin
      byte_valid = 1'b0;
      byte_data = ~last_q;
    end
  end
endmodule
`default_nettype wire

// ===== verif/ofd_decoder_props.sv
// Checker on decoder outputs, judged at the completion pulse.
// Assumes the decoder top ports; attached by bind.
`default_nettype none
module ofd_decoder_chk (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic dec_valid,
  input wire ofd_pkg::ofd_op_t dec_op,
  input wire logic [7:0] dec_opcode,
  input wire logic [7:0] dec_modrm,
  input wire logic dec_has_modrm,
  input wire logic dec_wide,
  input wire logic [3:0] dec_cond,
  input wire logic [5:0] dec_hand_off,
  input wire logic [2:0] dec_disp_bytes,
  input wire logic [2:0] dec_imm_bytes
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire logic [1:0] md = dec_modrm[7:6];
  wire logic [7:0] o = dec_opcode;
  chk_cond_class: assert property (dec_valid && o[7:4] == 4'h7 |->
    dec_op == ofd_pkg::OFD_BR_COND && dec_cond == o[3:0]
    && dec_imm_bytes == 3'h1) else $error("cond branch decode wrong");
  chk_width_bit: assert property (dec_valid |-> dec_wide == o[0])
    else $error("width bit wrong");
  chk_hand_off: assert property (dec_valid && o[7:3] == 5'h1B |->
    dec_op == ofd_pkg::OFD_HAND_OFF && dec_has_modrm
    && dec_hand_off == {o[2:0], dec_modrm[5:3]}) else $error("hand-off wrong");
  chk_single_byte: assert property (dec_valid && (o == 8'h37 ||
    o == 8'h27 || o == 8'hF0 || o == 8'hF4 || o == 8'h9B) |->
    !dec_has_modrm && dec_imm_bytes == 3'h0) else $error("extra bytes");
  chk_disp_count: assert property (dec_valid && dec_has_modrm |->
    dec_disp_bytes == (md == 2'h1 ? 3'h1 : (md == 2'h2 ||
    (md == 2'h0 && dec_modrm[2:0] == 3'h6)) ? 3'h2 : 3'h0))
    else $error("displacement count wrong");
  chk_acc_imm: assert property (dec_valid && o[7:6] == 2'h0 &&
    o[2:1] == 2'h2 && o[5:3] inside {3'h0, 3'h2, 3'h5, 3'h3} |->
    dec_imm_bytes == {2'h0, o[0]} + 3'h1) else $error("acc imm wrong");
  chk_group_imm: assert property (dec_valid && o[7:2] == 6'h20 |->
    dec_has_modrm && dec_imm_bytes == (o[1:0] == 2'h1 ? 3'h2 : 3'h1))
    else $error("group imm wrong");
  chk_far_branch: assert property (dec_valid && o == 8'hEA |->
    dec_op == ofd_pkg::OFD_BR_FAR && dec_imm_bytes == 3'h4
    && !dec_has_modrm) else $error("far branch wrong");
  cov_hand: cover property (dec_valid && dec_op == ofd_pkg::OFD_HAND_OFF);
  cov_long: cover property (dec_valid && dec_disp_bytes == 3'h2
    && dec_imm_bytes == 3'h2);
  cov_b2b: cover property (dec_valid ##1 dec_valid);
endmodule
bind ofd_decoder ofd_decoder_chk chk_i (.core_clk, .reset_n, .dec_valid,
  .dec_op, .dec_opcode, .dec_modrm, .dec_has_modrm, .dec_wide, .dec_cond,
  .dec_hand_off, .dec_disp_bytes, .dec_imm_bytes);
`default_nettype wire

// ===== verif/tb.sv
// Bench: reference decode model compared at every completion pulse.
// Assumes one 10 MHz clock and the queue model on the byte side.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic stall = 1'b0;
  logic byte_valid, byte_ready, dec_valid, dec_has_modrm, dec_wide;
  logic dec_dir, dec_sign_ext;
  logic [7:0] byte_data, dec_opcode, dec_modrm;
  logic [3:0] dec_cond;
  logic [5:0] dec_hand_off;
  logic [2:0] dec_disp_bytes, dec_imm_bytes;
  ofd_pkg::ofd_op_t dec_op;
  logic [31:0] seed = 32'h0001746B;
  logic [41:0] xq [$];
  logic [41:0] xv;
  int lq [$];
  int errors = 0, checks_done = 0, taken = 0, ends = 0, cycles = 0;
  logic [7:0] tbl [$] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h13, 8'h28,
    8'h2B, 8'h18, 8'h1A, 8'h38, 8'h39, 8'h04, 8'h05, 8'h14, 8'h15, 8'h2C,
    8'h2D, 8'h1C, 8'h1D, 8'h80, 8'h81, 8'h82, 8'h83, 8'hFE, 8'hFF, 8'hF6,
    8'hF7, 8'h40, 8'h4F, 8'h37, 8'h27, 8'hE9, 8'hEB, 8'hEA, 8'hC3, 8'hCB,
    8'hC2, 8'hCA, 8'h74, 8'h75, 8'hE2, 8'hE1, 8'hE0, 8'hE3, 8'hCD, 8'hCC,
    8'hCE, 8'hCF, 8'hF0, 8'hF4, 8'h9B, 8'hD8, 8'hDF, 8'h06, 8'h50, 8'h48};
  ofd_decoder uut (.core_clk, .reset_n, .byte_valid, .byte_data,
    .byte_ready, .dec_valid, .dec_op, .dec_opcode, .dec_modrm,
    .dec_has_modrm, .dec_wide, .dec_dir, .dec_sign_ext, .dec_cond,
    .dec_hand_off, .dec_disp_bytes, .dec_imm_bytes);
  ofd_queue_model qm (.core_clk, .reset_n, .byte_ready, .stall,
    .byte_valid, .byte_data);
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic ofd_pkg::ofd_op_t exp_op(logic [7:0] o, logic [2:0] r);
    casez (o)
      8'b000000??, 8'b0000010?: return ofd_pkg::OFD_SUM;
      8'b000100??, 8'b0001010?: return ofd_pkg::OFD_SUM_CARRY;
      8'b001010??, 8'b0010110?: return ofd_pkg::OFD_DIFF;
      8'b000110??, 8'b0001110?: return ofd_pkg::OFD_DIFF_BORROW;
      8'b001110??: return ofd_pkg::OFD_COMPARE;
      8'b100000??: return r == 0 ? ofd_pkg::OFD_SUM : r == 2 ?
        ofd_pkg::OFD_SUM_CARRY : r == 5 ? ofd_pkg::OFD_DIFF : r == 3 ?
        ofd_pkg::OFD_DIFF_BORROW : r == 7 ? ofd_pkg::OFD_COMPARE :
        ofd_pkg::OFD_UNKNOWN;
      8'b1111111?: return r == 0 ? ofd_pkg::OFD_PLUS_ONE : r == 1 ?
        ofd_pkg::OFD_MINUS_ONE : o[0] && r == 4 ? ofd_pkg::OFD_BR_IND_NEAR
        : o[0] && r == 5 ? ofd_pkg::OFD_BR_IND_FAR : ofd_pkg::OFD_UNKNOWN;
      8'b1111011?: return r == 3 ? ofd_pkg::OFD_TWOS_COMP :
        ofd_pkg::OFD_UNKNOWN;
      8'b01000???: return ofd_pkg::OFD_PLUS_ONE;
      8'b01001???: return ofd_pkg::OFD_MINUS_ONE;
      8'b0111????: return ofd_pkg::OFD_BR_COND;
      8'b11011???: return ofd_pkg::OFD_HAND_OFF;
      8'h37: return ofd_pkg::OFD_ASCII_FIX;
      8'h27: return ofd_pkg::OFD_BCD_FIX;
      8'hE9: return ofd_pkg::OFD_BR_NEAR;
      8'hEB: return ofd_pkg::OFD_BR_SHORT;
      8'hEA: return ofd_pkg::OFD_BR_FAR;
      8'hC3, 8'hC2: return ofd_pkg::OFD_EXIT_NEAR;
      8'hCB, 8'hCA: return ofd_pkg::OFD_EXIT_FAR;
      8'hE2: return ofd_pkg::OFD_COUNT_BR;
      8'hE1: return ofd_pkg::OFD_COUNT_BR_ZERO;
      8'hE0: return ofd_pkg::OFD_COUNT_BR_NONZERO;
      8'hE3: return ofd_pkg::OFD_BR_CNT_ZERO;
      8'hCD: return ofd_pkg::OFD_TRAP_VEC;
      8'hCC: return ofd_pkg::OFD_TRAP3;
      8'hCE: return ofd_pkg::OFD_TRAP_OVF;
      8'hCF: return ofd_pkg::OFD_TRAP_EXIT;
      8'hF0: return ofd_pkg::OFD_LOCK;
      8'hF4: return ofd_pkg::OFD_HALT;
      8'h9B: return ofd_pkg::OFD_COPROC_SYNC;
      default: return ofd_pkg::OFD_UNKNOWN;
    endcase
  endfunction
  function automatic logic has_m(logic [7:0] o);
    casez (o)
      8'b000000??, 8'b000100??, 8'b001010??, 8'b000110??, 8'b001110??,
      8'b100000??, 8'b1111?11?, 8'b11011???: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [2:0] imm_of(logic [7:0] o);
    casez (o)
      8'b0000010?, 8'b0001010?, 8'b0010110?, 8'b0001110?:
        return {2'h0, o[0]} + 3'h1;
      8'b100000??: return o[1:0] == 2'h1 ? 3'h2 : 3'h1;
      8'hE9, 8'hC2, 8'hCA: return 3'h2;
      8'hEA: return 3'h4;
      8'b0111????, 8'b111000??, 8'hEB, 8'hCD: return 3'h1;
      default: return 3'h0;
    endcase
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic send(input logic [7:0] o);
    logic [7:0] m;
    logic hm;
    int d;
    m = 8'(rnd());
    // Other reg fields of this group carry unspecified data bytes
    if (o[7:1] == 7'h7B) m[5:3] = 3'h3;
    hm = has_m(o);
    d = !hm ? 0 : m[7:6] == 2'h1 ? 1 : (m[7:6] == 2'h2 ||
      (m[7:6] == 2'h0 && m[2:0] == 3'h6)) ? 2 : 0;
    qm.push(o);
    if (hm) qm.push(m);
    repeat (d + imm_of(o)) qm.push(8'(rnd()));
    lq.push_back(1 + hm + d + imm_of(o));
    xq.push_back({exp_op(o, m[5:3]), o, hm ? m : 8'h00, hm, o[0],
      o[1] && o[7:2] != 6'h20, o[1] && o[7:2] == 6'h20, d[2:0], imm_of(o),
      o[7:4] == 4'h7 ? o[3:0] : 4'h0,
      o[7:3] == 5'h1B ? {o[2:0], m[5:3]} : 6'h00});
  endtask
  always @(posedge core_clk) begin
    if (byte_valid === 1'b1) taken++;
    stall <= rnd() % 3 == 0;
    cycles++;
    if (cycles > 40000) begin
      errors++;
      end_sim();
    end
  end
  // Results are registered: look mid-cycle, away from the launching edge
  always @(negedge core_clk) begin
    if (dec_valid === 1'b1) begin
      xv = xq.pop_front();
      ends += lq.pop_front();
      check(taken, ends);
      check(dec_op, xv[41:36]);
      check({dec_opcode, dec_modrm, dec_has_modrm}, xv[35:19]);
      check({dec_wide, dec_dir, dec_sign_ext}, xv[18:16]);
      check({dec_disp_bytes, dec_imm_bytes}, xv[15:10]);
      check(dec_opcode[7:4] == 4'h7 ? dec_cond : 4'h0, xv[9:6]);
      check(dec_opcode[7:3] == 5'h1B ? dec_hand_off : 6'h00,
        xv[5:0]);
    end
  end
  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    check({byte_ready, dec_valid, dec_op}, {2'h2, ofd_pkg::OFD_NONE});
    for (int p = 0; p < 6; p++) begin
      foreach (tbl[i]) send(tbl[i]);
      send({4'h7, 4'(rnd())});
      while (xq.size() != 0) @(posedge core_clk);
      $display("pass %0d done", p);
    end
    repeat (4) @(posedge core_clk);
    end_sim();
  end
endmodule
`default_nettype wire
